// file: shared/dtp_defs.svh
`ifndef DTP_DEFS_SVH
`define DTP_DEFS_SVH

// ----------------------------------------
// clock, tick and modulator timing
// ----------------------------------------
`define DTP_CLK_HZ 10000000
`define DTP_TICK_CYC 1024
`define DTP_PWM_COUNTS 256
`define DTP_PRESCALE 4
`define DTP_MS_DIV 1000
`define DTP_TONE_MS 50
`define DTP_GAP_MS 50

// ----------------------------------------
// phase accumulator and table
// ----------------------------------------
`define DTP_ACC_W 16
`define DTP_IDX_W 7
`define DTP_TBL_LEN 128
`define DTP_MID_WIDTH 8'h80
`define DTP_RAMP_STEP 8'h01
`define DTP_FIFO_DEPTH 8

// ----------------------------------------
// tone frequencies in hertz
// ----------------------------------------
`define DTP_F_L0 697
`define DTP_F_L1 770
`define DTP_F_L2 852
`define DTP_F_L3 941
`define DTP_F_H0 1209
`define DTP_F_H1 1335
`define DTP_F_H2 1477
`define DTP_F_H3 1633

`endif

// file: shared/dtp_pkg.sv
`include "dtp_defs.svh"

package dtp_pkg;

    typedef enum logic [3:0] {
        ST_OFF = 4'b0001,
        ST_RAMP = 4'b0010,
        ST_GAP = 4'b0100,
        ST_TONE = 4'b1000
    } dtp_state_e;

    typedef logic [7:0] dtp_width_t;
    typedef logic [`DTP_ACC_W-1:0] dtp_acc_t;

    // phase step = 65536 * f / fs, fs = clk / tick, rounded to nearest
    function automatic dtp_acc_t dtp_step(input longint f_hz, input longint clk_hz);
        longint num;
        num = (longint'(1) << `DTP_ACC_W) * f_hz * `DTP_TICK_CYC;
        return dtp_acc_t'((num + clk_hz / 2) / clk_hz);
    endfunction : dtp_step

endpackage : dtp_pkg

// file: shared/dtp_stream_if.sv
`timescale 1ns/1ps

// sample stream between generator and modulator
interface dtp_stream_if #(parameter int W = 8);
    logic wr_valid;
    logic wr_ready;
    logic [W-1:0] wr_data;
    logic rd_valid;
    logic rd_ready;
    logic [W-1:0] rd_data;
    logic flush;

    modport src (output wr_valid, wr_data, rd_ready, flush, input wr_ready, rd_valid, rd_data);
    modport fifo (input wr_valid, wr_data, rd_ready, flush, output wr_ready, rd_valid, rd_data);
endinterface : dtp_stream_if

// file: rtl/dtp_fifo.sv
`timescale 1ns/1ps

module dtp_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    input wire logic i_clk,
    input wire logic i_reset,
    dtp_stream_if.fifo s
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp, rp, next_wp, next_rp;
    logic [AW:0] cnt, next_cnt;
    logic push, pop;

    // ----------------------------------------
    // handshakes
    // ----------------------------------------
    assign s.wr_ready = (cnt != (AW+1)'(DEPTH));
    assign s.rd_valid = (cnt != '0);
    assign s.rd_data = mem[rp];
    assign push = s.wr_valid && s.wr_ready && !s.flush;
    assign pop = s.rd_valid && s.rd_ready && !s.flush;

    // pointer arithmetic; flush wins so stale samples never leak out
    always_comb begin
        next_wp = wp;
        next_rp = rp;
        next_cnt = cnt;
        if (s.flush) begin
            next_wp = '0;
            next_rp = '0;
            next_cnt = '0;
        end else begin
            if (push) next_wp = (wp == AW'(DEPTH-1)) ? '0 : wp + 1'b1;
            if (pop) next_rp = (rp == AW'(DEPTH-1)) ? '0 : rp + 1'b1;
            next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            wp <= next_wp;
            rp <= next_rp;
            cnt <= next_cnt;
        end
    end

    // storage has no reset; only written words are ever read
    always_ff @(posedge i_clk) begin
        if (push) mem[wp] <= s.wr_data;
    end

endmodule : dtp_fifo

// file: rtl/dtp_top.sv
`timescale 1ns/1ps
`include "dtp_defs.svh"

// What this block does
// RULE1: each of sixteen key codes maps to one fixed low and high tone
// RULE2: while a digit is active two different tones sound together
// RULE3: two independent phase counters step one shared sine table, own step each
// RULE4: each sample is the sum of the two table values
// RULE5: sine table has 128 entries covering one full period
// RULE6: entries unsigned, start 63, peak 126, minimum 0
// RULE7: modulator period 256 counts, counter prescaled by 4
// RULE8: output pin starts one pulse every 1024 clocks
// RULE9: sample tick every 1024 clocks loads new width into width register
// RULE10: pulse high time equals the held width value
// RULE11: phase counters are 16 bit, one cycle is 65536 steps
// RULE12: step equals 65536 times tone frequency over sample rate
// RULE13: sample rate is system clock over 1024
// RULE14: table index is top 7 bits of each accumulator
// RULE15: step values follow the tabulated figures for the clock in use
// RULE16: tones stay within 1.5 percent given an accurate clock
// RULE17: step values are recomputed from the clock rate
// RULE18: digits held at least 50 ms, gaps at least 50 ms
// RULE19: larger table allowed if index width is adjusted to match
// RULE20: on enable width ramps linearly from 0 to 128
// RULE21: between digits width stays 128, modulator keeps running
// RULE22: accumulators wrap modulo 65536, steps rounded to nearest
// RULE23: sum at most 252 loads directly as the width
module dtp_top
    import dtp_pkg::*;
#(
    parameter longint CLK_HZ = `DTP_CLK_HZ,
    parameter int TONE_MIN_CYC = `DTP_TONE_MS * (`DTP_CLK_HZ / `DTP_MS_DIV),
    parameter int GAP_MIN_CYC = `DTP_GAP_MS * (`DTP_CLK_HZ / `DTP_MS_DIV)
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_enable,
    input wire logic i_key_valid,
    input wire logic [3:0] i_key,
    output logic o_pulse_width_output_pin,
    output logic o_tone_active,
    output dtp_pkg::dtp_width_t o_width
);
    import dtp_pkg::*;

    // ----------------------------------------
    // sine table and tone lookup
    // ----------------------------------------
    localparam logic [6:0] SINE [`DTP_TBL_LEN] = '{ // RULE5 RULE6
        7'h3F, 7'h42, 7'h45, 7'h48, 7'h4B, 7'h4E, 7'h51, 7'h54,
        7'h57, 7'h5A, 7'h5D, 7'h5F, 7'h62, 7'h65, 7'h67, 7'h69,
        7'h6C, 7'h6E, 7'h70, 7'h72, 7'h74, 7'h75, 7'h77, 7'h78,
        7'h7A, 7'h7B, 7'h7C, 7'h7D, 7'h7D, 7'h7E, 7'h7E, 7'h7E,
        7'h7E, 7'h7E, 7'h7E, 7'h7E, 7'h7D, 7'h7D, 7'h7C, 7'h7B,
        7'h7A, 7'h78, 7'h77, 7'h75, 7'h74, 7'h72, 7'h70, 7'h6E,
        7'h6C, 7'h69, 7'h67, 7'h65, 7'h62, 7'h5F, 7'h5D, 7'h5A,
        7'h57, 7'h54, 7'h51, 7'h4E, 7'h4B, 7'h48, 7'h45, 7'h42,
        7'h3F, 7'h3B, 7'h38, 7'h35, 7'h32, 7'h2F, 7'h2C, 7'h29,
        7'h26, 7'h23, 7'h20, 7'h1E, 7'h1B, 7'h18, 7'h16, 7'h14,
        7'h11, 7'h0F, 7'h0D, 7'h0B, 7'h09, 7'h08, 7'h06, 7'h05,
        7'h03, 7'h02, 7'h01, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00,
        7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h01, 7'h02,
        7'h03, 7'h05, 7'h06, 7'h08, 7'h09, 7'h0B, 7'h0D, 7'h0F,
        7'h11, 7'h14, 7'h16, 7'h18, 7'h1B, 7'h1E, 7'h20, 7'h23,
        7'h26, 7'h29, 7'h2C, 7'h2F, 7'h32, 7'h35, 7'h38, 7'h3B
    };

    // steps derived from the clock, so another rate needs no hand edits
    localparam dtp_acc_t STEP_LO [4] = '{ // RULE12 RULE13 RULE15 RULE16 RULE17 RULE22
        dtp_step(`DTP_F_L0, CLK_HZ), dtp_step(`DTP_F_L1, CLK_HZ),
        dtp_step(`DTP_F_L2, CLK_HZ), dtp_step(`DTP_F_L3, CLK_HZ)
    };
    localparam dtp_acc_t STEP_HI [4] = '{
        dtp_step(`DTP_F_H0, CLK_HZ), dtp_step(`DTP_F_H1, CLK_HZ),
        dtp_step(`DTP_F_H2, CLK_HZ), dtp_step(`DTP_F_H3, CLK_HZ)
    };

    // key code 0-9, A-D as 10-13, star 14, hash 15; returns {row, column}
    function automatic logic [3:0] key_pair(input logic [3:0] k);
        case (k)
            4'h1: key_pair = 4'h0; // RULE1
            4'h2: key_pair = 4'h1;
            4'h3: key_pair = 4'h2;
            4'h4: key_pair = 4'h4;
            4'h5: key_pair = 4'h5;
            4'h6: key_pair = 4'h6;
            4'h7: key_pair = 4'h8;
            4'h8: key_pair = 4'h9;
            4'h9: key_pair = 4'hA;
            4'hA: key_pair = 4'h3;
            4'hB: key_pair = 4'h7;
            4'hC: key_pair = 4'hB;
            4'hD: key_pair = 4'hF;
            4'hE: key_pair = 4'hC;
            4'hF: key_pair = 4'hE;
            default: key_pair = 4'hD;
        endcase
    endfunction : key_pair

    function automatic logic [6:0] sine_at(input dtp_acc_t acc);
        sine_at = SINE[acc[`DTP_ACC_W-1 -: `DTP_IDX_W]]; // RULE14 RULE19
    endfunction : sine_at

    dtp_stream_if #(.W(8)) strm ();

    dtp_fifo #(.W(8), .DEPTH(`DTP_FIFO_DEPTH)) u_fifo (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .s(strm.fifo)
    );

    // ----------------------------------------
    // modulator: 256 counts, divide-by-4
    // ----------------------------------------
    logic [1:0] pre, next_pre;
    logic [7:0] cnt, next_cnt;
    dtp_width_t width, next_width;
    logic per_end;

    assign per_end = (pre == 2'(`DTP_PRESCALE - 1)) && (cnt == 8'(`DTP_PWM_COUNTS - 1)); // RULE8

    always_comb begin
        next_pre = pre + 2'h1; // RULE7
        next_cnt = (pre == 2'(`DTP_PRESCALE - 1)) ? cnt + 8'h01 : cnt;
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            pre <= 2'h0;
            cnt <= 8'h00;
        end else begin
            pre <= next_pre;
            cnt <= next_cnt;
        end
    end

    // ----------------------------------------
    // sequence control
    // ----------------------------------------
    dtp_state_e state, next_state;
    logic [3:0] pair, next_pair;
    logic [31:0] hold, next_hold;
    logic hold_done;

    assign hold_done = (state == ST_TONE) ? (hold >= 32'(TONE_MIN_CYC))
                                          : (hold >= 32'(GAP_MIN_CYC));

    // a key press is taken only once the gap has lasted its minimum
    always_comb begin
        next_state = state;
        next_pair = pair;
        next_hold = (hold == 32'hFFFFFFFF) ? hold : hold + 32'h1;
        case (state)
            ST_OFF: begin
                if (i_enable) next_state = ST_RAMP;
            end
            ST_RAMP: begin
                if (per_end && width == `DTP_MID_WIDTH) begin
                    next_state = ST_GAP;
                    next_hold = 32'h0;
                end
            end
            ST_GAP: begin
                if (i_key_valid && hold_done) begin // RULE18
                    next_state = ST_TONE;
                    next_pair = key_pair(i_key);
                    next_hold = 32'h0;
                end
            end
            ST_TONE: begin
                if (!i_key_valid && hold_done) begin // RULE18
                    next_state = ST_GAP;
                    next_hold = 32'h0;
                end
            end
            default: next_state = ST_OFF;
        endcase
        if (!i_enable) next_state = ST_OFF;
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state <= ST_OFF;
            pair <= 4'h0;
            hold <= 32'h0;
        end else begin
            state <= next_state;
            pair <= next_pair;
            hold <= next_hold;
        end
    end

    // ----------------------------------------
    // dual phase accumulators into the FIFO
    // ----------------------------------------
    dtp_acc_t acc_lo, acc_hi, next_acc_lo, next_acc_hi;
    logic push;

    // generator runs ahead until the FIFO is full, then stalls
    assign push = (state == ST_TONE) && strm.wr_ready;
    assign strm.wr_valid = (state == ST_TONE);
    assign strm.wr_data = {1'b0, sine_at(acc_lo)} + {1'b0, sine_at(acc_hi)}; // RULE2 RULE4
    assign strm.flush = (state != ST_TONE);
    assign strm.rd_ready = per_end && (state == ST_TONE);

    always_comb begin
        next_acc_lo = acc_lo;
        next_acc_hi = acc_hi;
        if (state != ST_TONE) begin
            next_acc_lo = '0;
            next_acc_hi = '0;
        end else if (push) begin
            next_acc_lo = acc_lo + STEP_LO[pair[3:2]]; // RULE3 RULE11 RULE22
            next_acc_hi = acc_hi + STEP_HI[pair[1:0]]; // RULE3 RULE11 RULE22
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            acc_lo <= '0;
            acc_hi <= '0;
        end else begin
            acc_lo <= next_acc_lo;
            acc_hi <= next_acc_hi;
        end
    end

    // ----------------------------------------
    // width register, loaded once per period, cleared at once in ST_OFF
    // ----------------------------------------
    always_comb begin
        next_width = width;
        if (per_end) begin // RULE9
            case (state)
                ST_OFF: next_width = 8'h00;
                ST_RAMP: next_width = (width < `DTP_MID_WIDTH) ? width + `DTP_RAMP_STEP
                                                              : `DTP_MID_WIDTH; // RULE20
                ST_GAP: next_width = `DTP_MID_WIDTH; // RULE21
                ST_TONE: next_width = strm.rd_valid ? strm.rd_data : width; // RULE23
                default: next_width = 8'h00;
            endcase
        end
        if (state == ST_OFF) next_width = 8'h00;
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) width <= 8'h00;
        else width <= next_width;
    end

    // pin and status come from flip-flops; pin is high while count < width
    logic pin, next_pin;
    assign next_pin = (next_cnt < next_width); // RULE10
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            pin <= 1'b0;
            o_tone_active <= 1'b0;
            o_width <= 8'h00;
        end else begin
            pin <= next_pin;
            o_tone_active <= (next_state == ST_TONE);
            o_width <= next_width;
        end
    end
    assign o_pulse_width_output_pin = pin;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    logic [9:0] since;
    logic [10:0] hi_cnt;
    logic w_steady;
    // switch-off forces the width mid-period; such a period is not judged on high time
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            since <= 10'h000;
            hi_cnt <= 11'h000;
            w_steady <= 1'b0;
        end else begin
            since <= per_end ? 10'h000 : since + 10'h001;
            hi_cnt <= per_end ? 11'(pin) : hi_cnt + 11'(pin);
            w_steady <= per_end || (w_steady && (next_width == width));
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    a_period_spacing: assert property (per_end |-> since == 10'h3FF) // RULE8
        else $error("modulator period is not 1024 clocks");
    a_high_time: assert property (per_end && w_steady |-> hi_cnt == {1'b0, width, 2'b00}) // RULE10
        else $error("pulse high time does not match width");
    a_push_only_tone: assert property (strm.wr_valid |-> state == ST_TONE && // RULE2
        (!$past(strm.wr_valid) || pair == $past(pair)))
        else $error("sample produced outside a tone");
    a_sum_bound: assert property (strm.wr_valid |-> strm.wr_data <= 8'hFC) // RULE23
        else $error("sample sum exceeds 252");
    a_acc_step: assert property (push ##1 state == ST_TONE |-> // RULE3
        acc_lo == $past(acc_lo) + STEP_LO[pair[3:2]])
        else $error("low accumulator did not advance by its step");
    a_gap_width: assert property (state == ST_GAP && per_end |=> width == `DTP_MID_WIDTH) // RULE21
        else $error("gap width is not midpoint");
    a_ramp_linear: assert property (state == ST_RAMP && per_end && width < `DTP_MID_WIDTH |=> // RULE20
        width == $past(width) + 8'h01)
        else $error("ramp is not linear");
    a_tone_hold: assert property (state == ST_TONE && i_enable ##1 state == ST_GAP |-> // RULE18
        $past(hold) >= 32'(TONE_MIN_CYC))
        else $error("tone ended before its minimum");
    a_off_quiet: assert property (state == ST_OFF ##1 state == ST_OFF |-> // RULE7
        !o_pulse_width_output_pin)
        else $error("pin active while disabled");

    c_tone_start: cover property (state == ST_GAP ##1 state == ST_TONE);
    c_ramp_done: cover property (state == ST_RAMP ##1 state == ST_GAP);
    c_fifo_full: cover property (state == ST_TONE && !strm.wr_ready);
    c_tone_end: cover property (state == ST_TONE ##1 state == ST_GAP);

endmodule : dtp_top

// file: tb/dtp_lpf_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// filter side of the pulse pin
// ----------------------------------------
// an integrator only sees duty, so it reports the high time and the rise spacing
module dtp_lpf_model (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_pin,
    output logic [15:0] o_high_len,
    output logic [15:0] o_period
);
    logic prev_pin;
    logic seen_rise;
    logic [15:0] run_cnt;
    logic [15:0] since_rise;

    // measure each pulse; the first rise has no spacing yet, so period stays 0 until the second
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            prev_pin <= 1'b0;
            seen_rise <= 1'b0;
            run_cnt <= 16'h0000;
            since_rise <= 16'h0000;
            o_high_len <= 16'h0000;
            o_period <= 16'h0000;
        end else begin
            prev_pin <= i_pin;
            since_rise <= since_rise + 16'h0001;
            if (i_pin) begin
                run_cnt <= run_cnt + 16'h0001;
            end
            if (i_pin && !prev_pin) begin
                since_rise <= 16'h0001;
                seen_rise <= 1'b1;
                if (seen_rise) begin
                    o_period <= since_rise;
                end
            end
            if (!i_pin && prev_pin) begin
                o_high_len <= run_cnt;
                run_cnt <= 16'h0000;
            end
        end
    end
endmodule : dtp_lpf_model

// file: tb/dtp_tone_pwm_synth_tb_top.sv
`timescale 1ns/1ps
`include "dtp_defs.svh"

module dtp_tone_pwm_synth_tb_top;
    import dtp_pkg::*;

    // ----------------------------------------
    // set-up
    // ----------------------------------------
    // a tone must outlast up to three judged pulses, the last one up to 1008 clocks high
    localparam int TONE_MIN = 4096;
    localparam int GAP_MIN = 2048;
    localparam int TBL [128] = '{
        63, 66, 69, 72, 75, 78, 81, 84, 87, 90, 93, 95, 98, 101, 103, 105,
        108, 110, 112, 114, 116, 117, 119, 120, 122, 123, 124, 125, 125, 126, 126, 126,
        126, 126, 126, 126, 125, 125, 124, 123, 122, 120, 119, 117, 116, 114, 112, 110,
        108, 105, 103, 101, 98, 95, 93, 90, 87, 84, 81, 78, 75, 72, 69, 66,
        63, 59, 56, 53, 50, 47, 44, 41, 38, 35, 32, 30, 27, 24, 22, 20,
        17, 15, 13, 11, 9, 8, 6, 5, 3, 2, 1, 0, 0, 0, 0, 0,
        0, 0, 0, 0, 0, 0, 1, 2, 3, 5, 6, 8, 9, 11, 13, 15,
        17, 20, 22, 24, 27, 30, 32, 35, 38, 41, 44, 47, 50, 53, 56, 59};
    localparam int LO_SEL [16] = '{3, 0, 0, 0, 1, 1, 1, 2, 2, 2, 0, 1, 2, 3, 3, 3};
    localparam int HI_SEL [16] = '{1, 0, 1, 2, 0, 1, 2, 0, 1, 2, 3, 3, 3, 3, 0, 2};
    localparam longint LO_F [4] = '{`DTP_F_L0, `DTP_F_L1, `DTP_F_L2, `DTP_F_L3};
    localparam longint HI_F [4] = '{`DTP_F_H0, `DTP_F_H1, `DTP_F_H2, `DTP_F_H3};

    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic i_enable = 1'b0;
    logic i_key_valid = 1'b0;
    logic [3:0] i_key = 4'h0;
    logic o_pin;
    logic o_tone_active;
    dtp_width_t o_width;
    logic [15:0] high_len;
    logic [15:0] period;
    int miscompares = 0;
    int check_count = 0;
    int cyc = 0;
    int t_gap = 0;

    always #50 i_clk = ~i_clk;
    always @(posedge i_clk) cyc <= cyc + 1;

    dtp_top #(.TONE_MIN_CYC(TONE_MIN), .GAP_MIN_CYC(GAP_MIN)) dtp_top_i (
        .i_clk(i_clk), .i_reset(i_reset), .i_enable(i_enable), .i_key_valid(i_key_valid),
        .i_key(i_key), .o_pulse_width_output_pin(o_pin), .o_tone_active(o_tone_active),
        .o_width(o_width));
    dtp_lpf_model dtp_lpf_model_i (.i_clk(i_clk), .i_reset(i_reset), .i_pin(o_pin),
        .o_high_len(high_len), .o_period(period));

    // ----------------------------------------
    // reference model and shared tasks
    // ----------------------------------------
    // phase step rounded to nearest, from the tick rate of the nominal clock
    function automatic longint step_of(input longint f);
        return (64'h10000 * f * `DTP_TICK_CYC + `DTP_CLK_HZ / 2) / `DTP_CLK_HZ;
    endfunction : step_of

    // sample n of a key: accumulators wrap at 16 bits, top 7 bits index the table
    function automatic logic [31:0] exp_sample(input int k, input int n);
        logic [15:0] a_lo;
        logic [15:0] a_hi;
        a_lo = 16'(longint'(n) * step_of(LO_F[LO_SEL[k]]));
        a_hi = 16'(longint'(n) * step_of(HI_F[HI_SEL[k]]));
        return 32'(TBL[a_lo[15:9]] + TBL[a_hi[15:9]]);
    endfunction : exp_sample

    task automatic end_sim;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_sim

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask : check

    task automatic give_up;
        miscompares++;
        $display("[FAIL] %0t wait ran out", $time);
        end_sim();
    endtask : give_up

    // next whole pulse: width in force at its rise, high time and spacing judged
    task automatic check_pulse(output dtp_width_t w);
        int n;
        n = 0;
        while (o_pin !== 1'b0) begin
            @(negedge i_clk);
            n++;
        end
        while (o_pin !== 1'b1) begin
            if (n > 2200) give_up();
            @(negedge i_clk);
            n++;
        end
        w = o_width;
        while (o_pin !== 1'b0) begin
            if (n > 3300) give_up();
            @(negedge i_clk);
            n++;
        end
        @(negedge i_clk);
        check(32'(high_len), 32'(w) * 32'h4);
        if (period != 16'h0000) check(32'(period), 32'h400);
    endtask : check_pulse

    // bounded wait on the tone flag, which the bench never drives
    task automatic wait_tone(input logic want, input int lim);
        int n;
        n = 0;
        while (o_tone_active !== want) begin
            if (n > lim) give_up();
            @(negedge i_clk);
            n++;
        end
    endtask : wait_tone

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // every period end raises the width by one until the midpoint
    task automatic t_ramp;
        dtp_width_t w;
        i_enable = 1'b1;
        for (int i = 1; i <= 128; i++) begin
            check_pulse(w);
            check(32'(w), i);
        end
        t_gap = cyc;
    endtask : t_ramp

    task automatic t_gap_idle;
        dtp_width_t w;
        repeat (3) begin
            check_pulse(w);
            check(32'(w), 32'h80);
        end
    endtask : t_gap_idle

    // one digit: early request held off, key change ignored, samples and hold times judged
    task automatic run_key(input int k, input bit tight);
        dtp_width_t w;
        int t_on;
        i_key = 4'(k);
        i_key_valid = 1'b1;
        wait_tone(1'b1, 4000);
        t_on = cyc;
        check(32'(t_on - t_gap >= GAP_MIN), 32'h1);
        if (tight) check(32'(t_on - t_gap <= GAP_MIN + 4), 32'h1);
        i_key = ~4'(k);
        i_key_valid = 1'b0;
        w = 8'h00;
        for (int i = 0; i < 3 && w !== 8'h7E; i++) check_pulse(w);
        check(32'(w), 32'h7E);
        for (int n = 1; n <= 2; n++) begin
            check_pulse(w);
            check(32'(w), exp_sample(k, n));
        end
        wait_tone(1'b0, 4000);
        t_gap = cyc;
        check(32'(t_gap - t_on >= TONE_MIN), 32'h1);
        check(32'(t_gap - t_on <= TONE_MIN + 4), 32'h1);
        check_pulse(w);
        check(32'(w), 32'h80);
    endtask : run_key

    // switching off drops the width at once and the pin goes quiet
    task automatic t_off;
        int highs;
        highs = 0;
        i_enable = 1'b0;
        repeat (2) @(negedge i_clk);
        check(32'(o_width), 32'h0);
        repeat (1100) @(negedge i_clk);
        repeat (1100) begin
            @(negedge i_clk);
            if (o_pin !== 1'b0) highs++;
        end
        check(highs, 32'h0);
    endtask : t_off

    // ----------------------------------------
    // main sequence, inputs change on the falling edge
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge i_clk);
        @(negedge i_clk);
        check({o_pin, o_tone_active, o_width}, 32'h0);
        i_reset = 1'b0;
        repeat (1100) @(negedge i_clk);
        check(32'(o_pin), 32'h0);
        t_ramp();
        t_gap_idle();
        for (int k = 0; k < 16; k++) run_key(k, k > 0);
        t_off();
        end_sim();
    end
endmodule : dtp_tone_pwm_synth_tb_top
